// ---- mmm_pkg.sv ----
// Purpose: shared constants of the six-output motor modulator
// Assumes: APB slave, 32-bit data, byte offsets, 25 MHz system clock
// Notes: duty slots run high0, low0, high1, low1, high2, low2
// Overview of operation
// R1: Off level of each output group equals its option bit, active level inverse.
// R2: Option bits are captured at reset; no software access can change them.
// R3: Without the motor option all six outputs stay undriven.
// R4: With the option, outputs undriven in reset, then driven at off level.
// R5: Duty values and divider sit in buffers, applied only at reload.
// R6: Reload every period, or once per 2, 4 or 8 periods.
// R7: Software sets ready; first reload after it transfers the buffers.
// R8: 2-bit field divides system clock by 1, 2, 4, 8; changes at reload.
// R9: Edge mode: 12-bit count rises to reload value, wraps to zero.
// R10: Center mode: count rises to reload value, then falls to zero.
// R11: Duty is 16-bit signed, compared with the unsigned 12-bit count.
// R12: Duty at or below zero never asserts; above reload always asserts.
// R13: Separate mode: every output from its own duty, no dead time.
// R14: Pair mode: high duty drives the pair, low complementary, dead time.
// R15: Phase select clear: high starts on, low starts off; set swaps. In separate mode the code starts low on as well.
// R16: Override forces selected outputs off; all others keep modulating.
// R17: Dead time is 0 to 255 system clocks, independent of the divider.
// R18: Both outputs of a pair off during dead time; period unchanged.
// R19: Pulses narrower than the limit in counter clocks are suppressed.
// R20: The narrow check sees pulse width after dead-time shortening.
// R21: With converter sync enabled, trigger at end of each period.
// R22: Center mode with sync also triggers at the period midpoint.
// R23: Sense hold samples always, or holds when any or all selected on.
// R24: A reload that transfers buffers raises an event pulse.
// R25: Reload coincides with the counter returning to zero.
package mmm_pkg;
	localparam int unsigned CNT_W = 12;
	localparam int unsigned DUTY_W = 16;
	localparam int unsigned DT_W = 8;
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL_A = 8'h00;
	localparam logic [7:0] OFS_CTRL_B = 8'h04;
	localparam logic [7:0] OFS_RELOAD = 8'h08;
	localparam logic [7:0] OFS_DEADTIME = 8'h0c;
	localparam logic [7:0] OFS_MINPULSE = 8'h10;
	localparam logic [7:0] OFS_OVERRIDE = 8'h14;
	localparam logic [7:0] OFS_SENSE_A = 8'h18;
	localparam logic [7:0] OFS_SENSE_B = 8'h1c;
	localparam logic [7:0] OFS_DUTY0 = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h38;
	// Control A fields
	localparam int unsigned CA_RUN = 0;
	localparam int unsigned CA_READY = 1;
	localparam int unsigned CA_SYNC = 2;
	localparam int unsigned CA_OVR = 3;
	localparam int unsigned CA_CENTER = 4;
	// Control B fields
	localparam int unsigned CB_SEP = 0;
	localparam int unsigned CB_PHASE = 1;
	localparam int unsigned CB_RSEL = 4;
	localparam int unsigned CB_DIV = 6;
	// Status fields
	localparam int unsigned ST_DOWN = 12;
	localparam int unsigned ST_READY = 13;
	localparam int unsigned ST_ON = 14;
	// Reset values
	localparam logic [11:0] RST_RELOAD = 12'hfff;
	localparam logic [7:0] RST_DEADTIME = 8'h00;
	localparam logic [7:0] RST_MINPULSE = 8'h00;
	// Sense hold modes
	localparam logic [1:0] SH_SAMPLE = 2'h0;
	localparam logic [1:0] SH_ANY = 2'h1;
	localparam logic [1:0] SH_ALL = 2'h2;
endpackage : mmm_pkg

// ---- mmm_pair_if.sv ----
// Purpose: signals of one output pair between modulator stages
// Assumes: one system clock
// Notes: act and flt levels are 1 for on, before polarity
`timescale 1ns/100ps
interface mmm_pair_if;
	logic comp;
	logic raw_h;
	logic raw_l;
	logic [7:0] dt;
	logic act_h;
	logic act_l;
	logic [7:0] mpl;
	logic tick;
	logic flt_h;
	logic flt_l;
	modport ctl (output comp, raw_h, raw_l, dt, mpl, tick,
		input flt_h, flt_l);
	modport dead (input comp, raw_h, raw_l, dt, output act_h, act_l);
	modport filt (input comp, act_h, act_l, mpl, tick,
		output flt_h, flt_l);
endinterface : mmm_pair_if

// ---- mmm_deadband.sv ----
// Purpose: dead-time insertion for one complementary pair
// Assumes: raw requests change on system clock edges
// Notes: bypassed in separate-channel mode
`timescale 1ns/100ps
module mmm_deadband (
	input wire logic clk_i,
	input wire logic rstn_i,
	mmm_pair_if.dead p
);
	typedef struct packed {
		logic [7:0] cnt;
		logic want;
		logic h;
		logic l;
	} mmm_db_s;
	mmm_db_s q;
	mmm_db_s d;

	assign p.act_h = q.h;
	assign p.act_l = q.l;

	// Turn-off is immediate, turn-on waits the gap in system clocks
	always_comb begin
		d = q;
		if (!p.comp) begin
			d.h = p.raw_h; // R13
			d.l = p.raw_l;
			d.want = p.raw_h;
			d.cnt = 8'h00;
		end else if (p.raw_h != q.want) begin
			d.want = p.raw_h;
			d.cnt = p.dt; // R17
			d.h = (p.dt == 8'h00) && p.raw_h;
			d.l = (p.dt == 8'h00) && !p.raw_h; // R14
		end else if (q.cnt != 8'h00) begin
			d.cnt = q.cnt - 8'h01;
			if (q.cnt == 8'h01) begin
				d.h = q.want; // R18
				d.l = !q.want;
			end
		end
		if (!rstn_i) begin
			d = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		q <= d;
	end

	chk_dead_gap: assert property (@(posedge clk_i) disable iff (!rstn_i)
		p.comp |-> !(q.h && q.l)) else $error("pair overlap"); // R18
endmodule : mmm_deadband

// ---- mmm_narrow_filt.sv ----
// Purpose: narrow-pulse suppression on both outputs of a pair
// Assumes: inputs already carry dead-time shortening
// Notes: judges each pulse by the width of the last one of its level
`timescale 1ns/100ps
module mmm_narrow_filt (
	input wire logic clk_i,
	input wire logic rstn_i,
	mmm_pair_if.filt p
);
	typedef struct packed {
		logic [1:0] o;
		logic [1:0] lvl;
		logic [1:0][7:0] run_w;
		logic [1:0][7:0] hi_w;
		logic [1:0][7:0] lo_w;
	} mmm_nf_s;
	mmm_nf_s q;
	mmm_nf_s d;
	logic [1:0] a;

	assign a = {p.act_h, p.act_l};
	assign p.flt_h = q.o[1];
	assign p.flt_l = q.o[0];

	// Duty is steady between reloads, so last width predicts the next
	always_comb begin
		d = q;
		for (int k = 0; k < 2; k++) begin
			if (a[k] != q.lvl[k]) begin
				d.lvl[k] = a[k];
				d.run_w[k] = 8'h00;
				if (q.lvl[k]) begin
					d.hi_w[k] = q.run_w[k];
				end else begin
					d.lo_w[k] = q.run_w[k];
				end
				if ((a[k] ? q.hi_w[k] : q.lo_w[k]) >= p.mpl) begin
					d.o[k] = a[k]; // R19 R20
				end
			end else begin
				if (p.tick && q.run_w[k] != 8'hff) begin
					d.run_w[k] = q.run_w[k] + 8'h01;
				end
				if (q.o[k] != q.lvl[k] && q.run_w[k] >= p.mpl) begin
					d.o[k] = q.lvl[k]; // R19
				end
			end
		end
		// Held levels must never make a pair overlap
		if (p.comp) begin
			d.o[1] = d.o[1] && !a[0];
			d.o[0] = d.o[0] && !a[1];
		end
		if (!rstn_i) begin
			d = '0;
			d.hi_w = '1;
			d.lo_w = '1;
		end
	end

	always_ff @(posedge clk_i) begin
		q <= d;
	end
endmodule : mmm_narrow_filt

// ---- mmm_modulator.sv ----
// Purpose: six-output motor modulator with APB register slave
// Assumes: option pins static; APB on the system clock
// Notes: outputs lag the counter by three clocks through the pair stages
`timescale 1ns/100ps
module mmm_modulator (
	input wire logic CLK_SYS_I,
	input wire logic RSTN_I,
	input wire logic OPT_MC_EN_I,
	input wire logic OPT_HI_OFF_I,
	input wire logic OPT_LO_OFF_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	output logic [2:0] HIGH_OUT_O,
	output logic [2:0] HIGH_OUT_OE_O,
	output logic [2:0] LOW_OUT_O,
	output logic [2:0] LOW_OUT_OE_O,
	output logic ADC_TRIG_O,
	output logic SENSE_HOLD_O,
	output logic RELOAD_EVT_O
);
	typedef struct packed {
		logic motor_ctrl_opt_enable;
		logic high_side_offstate_opt;
		logic low_side_offstate_opt;
		logic oe;
		logic run;
		logic ready;
		logic converter_sync_en;
		logic manual_override_en;
		logic center;
		logic separate_channels_sel;
		logic [2:0] pair_phase_sel;
		logic [1:0] reload_interval_sel;
		logic [1:0] div_buf;
		logic [1:0] clock_divide_sel;
		logic [11:0] rel_buf;
		logic [11:0] rel;
		logic [7:0] deadtime_count;
		logic [7:0] narrow_pulse_limit;
		logic [5:0] channel_force_off;
		logic [1:0] sense_hold_cfg_a;
		logic [5:0] sense_hold_cfg_b;
		logic [5:0][15:0] duty_buf;
		logic [5:0][15:0] duty_value;
		logic [2:0] pre;
		logic [11:0] cnt;
		logic down;
		logic [2:0] pcnt;
		logic [2:0] hi_o;
		logic [2:0] lo_o;
		logic adc;
		logic hold;
		logic rld_evt;
		logic [31:0] prdata;
		logic slverr;
	} mmm_state_s;

	mmm_state_s q;
	mmm_state_s d;
	logic tick;
	logic [11:0] cnt_inc;
	logic wrap_e;
	logic mid;
	logic pend;
	logic reload;
	logic [5:0] live;
	wire [5:0] on_v;

	// Low bits set for a power-of-two select of 1, 2, 4 or 8
	function automatic logic [2:0] mask3(input logic [1:0] sel);
		logic [3:0] m;
		m = (4'h1 << sel) - 4'h1;
		return m[2:0];
	endfunction : mask3

	// Duty slot of an address, 7 when none
	function automatic logic [2:0] duty_slot(input logic [7:0] a);
		logic [7:0] off;
		off = a - mmm_pkg::OFS_DUTY0;
		if (a >= mmm_pkg::OFS_DUTY0 && a < mmm_pkg::OFS_STATUS &&
			off[1:0] == 2'h0) begin
			return off[4:2];
		end
		return 3'h7;
	endfunction : duty_slot

	// Signed duty against unsigned count; on while count below duty
	function automatic logic cmp(input logic [15:0] dv,
		input logic [11:0] c);
		return $signed(dv) > $signed({4'h0, c}); // R11 R12
	endfunction : cmp

	// Counter clock enable from the free-running prescaler
	assign tick = q.run &&
		((q.pre & mask3(q.clock_divide_sel)) ==
		mask3(q.clock_divide_sel)); // R8
	assign cnt_inc = q.cnt + 12'h001;
	assign wrap_e = !q.center && q.cnt >= q.rel;
	assign mid = tick && q.center && !q.down && cnt_inc >= q.rel; // R22
	assign pend = tick &&
		(q.center ? (q.down && q.cnt <= 12'h001) : wrap_e); // R25
	assign reload = pend &&
		((q.pcnt & mask3(q.reload_interval_sel)) ==
		mask3(q.reload_interval_sel)); // R6

	// Pair stages: compare, dead time, narrow-pulse filter
	mmm_pair_if pr[3] ();
	for (genvar k = 0; k < 3; k++) begin : g_pair
		logic ch;
		assign ch = cmp(q.duty_value[2*k], q.cnt);
		assign pr[k].comp = !q.separate_channels_sel; // R14
		assign pr[k].raw_h = ch ^ q.pair_phase_sel[k]; // R15
		assign pr[k].raw_l = q.separate_channels_sel ?
			cmp(q.duty_value[2*k+1], q.cnt) ^ q.pair_phase_sel[k] :
			!(ch ^ q.pair_phase_sel[k]); // R13 R15
		assign pr[k].dt = q.deadtime_count;
		assign pr[k].mpl = q.narrow_pulse_limit;
		assign pr[k].tick = tick;
		assign on_v[2*k] = pr[k].flt_h;
		assign on_v[2*k+1] = pr[k].flt_l;
		mmm_deadband u_db (
			.clk_i(CLK_SYS_I),
			.rstn_i(RSTN_I),
			.p(pr[k])
		);
		mmm_narrow_filt u_nf (
			.clk_i(CLK_SYS_I),
			.rstn_i(RSTN_I),
			.p(pr[k])
		);
	end

	// Override touches only the selected outputs
	assign live = on_v & {6{q.run}} &
		~(q.channel_force_off & {6{q.manual_override_en}}); // R16

	// Next state of the whole block
	always_comb begin
		d = q;
		d.adc = 1'b0;
		d.rld_evt = 1'b0;
		d.pre = q.run ? q.pre + 3'h1 : 3'h0;
		if (!q.run) begin
			d.cnt = 12'h000;
			d.down = 1'b0;
			d.pcnt = 3'h0;
		end else if (tick) begin
			if (!q.center) begin
				d.down = 1'b0;
				d.cnt = wrap_e ? 12'h000 : cnt_inc; // R9
			end else if (!q.down) begin
				d.cnt = cnt_inc; // R10
				d.down = mid;
			end else if (q.cnt <= 12'h001) begin
				d.cnt = 12'h000; // R10
				d.down = 1'b0;
			end else begin
				d.cnt = q.cnt - 12'h001;
			end
		end
		if (pend) begin
			d.pcnt = q.pcnt + 3'h1;
		end
		// Buffers move only when software has declared them complete
		if (reload && q.ready) begin
			d.duty_value = q.duty_buf; // R5 R7
			d.rel = q.rel_buf;
			d.clock_divide_sel = q.div_buf; // R8
			d.ready = 1'b0;
			d.pre = 3'h0;
			d.rld_evt = 1'b1; // R24
		end
		d.adc = q.converter_sync_en && (pend || mid); // R21 R22
		// Output levels: active is the inverse of the off level
		for (int k = 0; k < 3; k++) begin
			d.hi_o[k] = live[2*k] ? !q.high_side_offstate_opt :
				q.high_side_offstate_opt; // R1
			d.lo_o[k] = live[2*k+1] ? !q.low_side_offstate_opt :
				q.low_side_offstate_opt; // R1
		end
		d.oe = q.motor_ctrl_opt_enable; // R3 R4
		case (q.sense_hold_cfg_a)
			mmm_pkg::SH_ANY: d.hold = |(live & q.sense_hold_cfg_b); // R23
			mmm_pkg::SH_ALL: d.hold = (q.sense_hold_cfg_b != 6'h00) &&
				&(live | ~q.sense_hold_cfg_b); // R23
			default: d.hold = 1'b0;
		endcase
		// Read data is captured in the setup phase
		if (PSEL_I && !PENABLE_I) begin
			d.prdata = 32'h0;
			d.slverr = 1'b0;
			case (PADDR_I)
				mmm_pkg::OFS_CTRL_A: begin
					d.prdata[mmm_pkg::CA_RUN] = q.run;
					d.prdata[mmm_pkg::CA_READY] = q.ready;
					d.prdata[mmm_pkg::CA_SYNC] = q.converter_sync_en;
					d.prdata[mmm_pkg::CA_OVR] = q.manual_override_en;
					d.prdata[mmm_pkg::CA_CENTER] = q.center;
				end
				mmm_pkg::OFS_CTRL_B: begin
					d.prdata[mmm_pkg::CB_SEP] = q.separate_channels_sel;
					d.prdata[mmm_pkg::CB_PHASE +: 3] = q.pair_phase_sel;
					d.prdata[mmm_pkg::CB_RSEL +: 2] = q.reload_interval_sel;
					d.prdata[mmm_pkg::CB_DIV +: 2] = q.div_buf;
				end
				mmm_pkg::OFS_RELOAD: d.prdata[11:0] = q.rel_buf;
				mmm_pkg::OFS_DEADTIME: d.prdata[7:0] = q.deadtime_count;
				mmm_pkg::OFS_MINPULSE: d.prdata[7:0] = q.narrow_pulse_limit;
				mmm_pkg::OFS_OVERRIDE: d.prdata[5:0] = q.channel_force_off;
				mmm_pkg::OFS_SENSE_A: d.prdata[1:0] = q.sense_hold_cfg_a;
				mmm_pkg::OFS_SENSE_B: d.prdata[5:0] = q.sense_hold_cfg_b;
				mmm_pkg::OFS_STATUS: begin
					d.prdata[11:0] = q.cnt;
					d.prdata[mmm_pkg::ST_DOWN] = q.down;
					d.prdata[mmm_pkg::ST_READY] = q.ready;
					d.prdata[mmm_pkg::ST_ON +: 6] = live;
				end
				default: begin
					if (duty_slot(PADDR_I) != 3'h7) begin
						d.prdata[15:0] = q.duty_buf[duty_slot(PADDR_I)];
					end else begin
						d.slverr = 1'b1;
					end
				end
			endcase
		end
		// Writes take effect at the access edge; a ready set wins
		if (PSEL_I && PENABLE_I && PWRITE_I) begin
			case (PADDR_I)
				mmm_pkg::OFS_CTRL_A: begin
					d.run = PWDATA_I[mmm_pkg::CA_RUN];
					d.converter_sync_en = PWDATA_I[mmm_pkg::CA_SYNC];
					d.manual_override_en = PWDATA_I[mmm_pkg::CA_OVR];
					d.center = PWDATA_I[mmm_pkg::CA_CENTER];
					if (PWDATA_I[mmm_pkg::CA_READY]) begin
						d.ready = 1'b1; // R7
					end
				end
				mmm_pkg::OFS_CTRL_B: begin
					d.separate_channels_sel = PWDATA_I[mmm_pkg::CB_SEP];
					d.pair_phase_sel = PWDATA_I[mmm_pkg::CB_PHASE +: 3];
					d.reload_interval_sel = PWDATA_I[mmm_pkg::CB_RSEL +: 2];
					d.div_buf = PWDATA_I[mmm_pkg::CB_DIV +: 2]; // R8
				end
				mmm_pkg::OFS_RELOAD: d.rel_buf = PWDATA_I[11:0];
				mmm_pkg::OFS_DEADTIME: d.deadtime_count = PWDATA_I[7:0];
				mmm_pkg::OFS_MINPULSE: d.narrow_pulse_limit = PWDATA_I[7:0];
				mmm_pkg::OFS_OVERRIDE: d.channel_force_off = PWDATA_I[5:0];
				mmm_pkg::OFS_SENSE_A: d.sense_hold_cfg_a = PWDATA_I[1:0];
				mmm_pkg::OFS_SENSE_B: d.sense_hold_cfg_b = PWDATA_I[5:0];
				default: begin
					if (duty_slot(PADDR_I) != 3'h7) begin
						d.duty_buf[duty_slot(PADDR_I)] = PWDATA_I[15:0]; // R5
					end
				end
			endcase
		end
		// Option bits are caught only while reset is held
		if (!RSTN_I) begin
			d = '0;
			d.motor_ctrl_opt_enable = OPT_MC_EN_I; // R2
			d.high_side_offstate_opt = OPT_HI_OFF_I;
			d.low_side_offstate_opt = OPT_LO_OFF_I;
			d.hi_o = {3{OPT_HI_OFF_I}};
			d.lo_o = {3{OPT_LO_OFF_I}};
			d.rel_buf = mmm_pkg::RST_RELOAD;
			d.rel = mmm_pkg::RST_RELOAD;
			d.deadtime_count = mmm_pkg::RST_DEADTIME;
			d.narrow_pulse_limit = mmm_pkg::RST_MINPULSE;
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		q <= d;
	end

	// Zero-wait slave; read data and error come from flops
	assign PREADY_O = 1'b1;
	assign PRDATA_O = q.prdata;
	assign PSLVERR_O = q.slverr;
	assign HIGH_OUT_O = q.hi_o;
	assign LOW_OUT_O = q.lo_o;
	assign HIGH_OUT_OE_O = {3{q.oe}}; // R3 R4
	assign LOW_OUT_OE_O = {3{q.oe}};
	assign ADC_TRIG_O = q.adc;
	assign SENSE_HOLD_O = q.hold;
	assign RELOAD_EVT_O = q.rld_evt;

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RSTN_I);

	sequence s_transfer;
		reload && q.ready;
	endsequence

	chk_opt_locked: assert property ($past(RSTN_I) |-> // R2
		$stable({q.motor_ctrl_opt_enable, q.high_side_offstate_opt,
		q.low_side_offstate_opt})) else $error("option bits changed");
	chk_hiz_unopt: assert property (!q.motor_ctrl_opt_enable |-> // R3
		HIGH_OUT_OE_O == 3'h0 && LOW_OUT_OE_O == 3'h0)
		else $error("outputs driven without option");
	chk_release_off: assert property ($rose(RSTN_I) |-> // R4
		HIGH_OUT_OE_O == 3'h0 ##1
		(HIGH_OUT_OE_O == {3{q.motor_ctrl_opt_enable}} &&
		HIGH_OUT_O == {3{q.high_side_offstate_opt}}))
		else $error("bad release sequence");
	chk_idle_level: assert property (!q.run |=> // R1
		HIGH_OUT_O == {3{q.high_side_offstate_opt}} &&
		LOW_OUT_O == {3{q.low_side_offstate_opt}})
		else $error("idle output not at off level");
	chk_buffer_hold: assert property (!(reload && q.ready) |=> // R5
		$stable(q.duty_value) && $stable(q.clock_divide_sel))
		else $error("active values moved without reload");
	chk_transfer: assert property (s_transfer |=> // R7
		q.duty_value == $past(q.duty_buf) && RELOAD_EVT_O)
		else $error("buffers not transferred"); // R24
	chk_every_period: assert property (pend && // R6
		q.reload_interval_sel == 2'h0 |-> reload)
		else $error("reload missed");
	chk_reload_zero: assert property (reload |=> q.cnt == 12'h000)
		else $error("reload away from zero"); // R25
	chk_edge_wrap: assert property (tick && wrap_e |=> // R9
		q.cnt == 12'h000) else $error("edge count did not wrap");
	chk_center_turn: assert property (mid ##1 !pend |-> q.down) // R10
		else $error("center count did not turn");
	chk_div_two: assert property (tick && q.run && // R8
		q.clock_divide_sel == 2'h1 && !(reload && q.ready) |=> !tick)
		else $error("divide by two ticked twice");
	chk_adc_trig: assert property (q.converter_sync_en && pend |=> // R21
		ADC_TRIG_O) else $error("missing converter trigger");
	chk_force_off: assert property (q.manual_override_en && // R16
		q.channel_force_off[0] |=> HIGH_OUT_O[0] ==
		q.high_side_offstate_opt) else $error("forced output active");
endmodule : mmm_modulator

// ---- mmm_drive_model.sv ----
// Purpose: gate-drive side of the six modulator pins
// Assumes: undriven pins are pulled low by the driver stage
// Notes: reports gate-on states and counts shoot-through cycles
`timescale 1ns/100ps
module mmm_drive_model (
	input wire logic clk_i,
	input wire logic [2:0] hi_i,
	input wire logic [2:0] hi_oe_i,
	input wire logic [2:0] lo_i,
	input wire logic [2:0] lo_oe_i,
	input wire logic hi_off_i,
	input wire logic lo_off_i,
	input wire logic pair_chk_i,
	output logic [2:0] hi_on_o,
	output logic [2:0] lo_on_o,
	output int overlap_o
);
	logic [2:0] pin_h;
	logic [2:0] pin_l;
	// Released pins fall to the pull-down, never hold the last level
	assign pin_h = hi_i & hi_oe_i;
	assign pin_l = lo_i & lo_oe_i;
	// A gate is on when its pin leaves the strap off level
	assign hi_on_o = pin_h ^ {3{hi_off_i}};
	assign lo_on_o = pin_l ^ {3{lo_off_i}};
	// Both switches of a leg on together would short the supply
	initial overlap_o = 0;
	always @(posedge clk_i) begin
		if (pair_chk_i && |(hi_on_o & lo_on_o)) begin
			overlap_o <= overlap_o + 1;
		end
	end
endmodule : mmm_drive_model

// ---- mmm_modulator_bench.sv ----
// Purpose: self-checking bench of the six-output modulator
// Assumes: zero-wait APB slave, divider 1 unless a test sets it
// Notes: pin timing is judged from run lengths, not absolute edges
`timescale 1ns/100ps
module mmm_modulator_bench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic mc_en = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic pair_chk = 1'b0;
	logic [31:0] rdata;
	logic serr;
	logic [31:0] prdata;
	logic pready, pslverr, adc, evt, shold;
	logic [2:0] hi, hi_oe, lo, lo_oe, hi_on, lo_on;
	logic [7:0] obs;
	int overlap;
	int n_errors = 0;
	int n_compared = 0;
	int n;
	// Index 0 high0 on, 3 low0 on, 4 low1 on, 5 hold, 6 reload, 7 trigger
	assign obs = {adc, evt, shold, lo_on[1:0], hi_on};
	initial forever #20 clk = ~clk;
	mmm_modulator u_mmm_modulator (.CLK_SYS_I(clk), .RSTN_I(rstn),
		.OPT_MC_EN_I(mc_en), .OPT_HI_OFF_I(1'b1), .OPT_LO_OFF_I(1'b0),
		.PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
		.PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(pslverr), .HIGH_OUT_O(hi),
		.HIGH_OUT_OE_O(hi_oe), .LOW_OUT_O(lo), .LOW_OUT_OE_O(lo_oe),
		.ADC_TRIG_O(adc), .SENSE_HOLD_O(shold), .RELOAD_EVT_O(evt));
	mmm_drive_model u_mmm_drive_model (.clk_i(clk), .hi_i(hi),
		.hi_oe_i(hi_oe), .lo_i(lo), .lo_oe_i(lo_oe), .hi_off_i(1'b1),
		.lo_off_i(1'b0), .pair_chk_i(pair_chk), .hi_on_o(hi_on),
		.lo_on_o(lo_on), .overlap_o(overlap));
	task finish_test;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	// One APB transfer; idle edge after it so strobes never re-assert at once
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rdata = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb
	// Length of the next full run of one level, sampled mid-cycle
	task run_len(input int i, input logic lv, output int k);
		k = 0;
		while (obs[i] !== ~lv) @(negedge clk);
		while (obs[i] !== lv) @(negedge clk);
		while (obs[i] === lv) begin
			k++;
			@(negedge clk);
		end
		@(posedge clk);
	endtask : run_len
	task cnt_on(input int i, output int k);
		k = 0;
		repeat (20) begin
			@(negedge clk);
			if (obs[i] === 1'b1) k++;
		end
		@(posedge clk);
	endtask : cnt_on
	// Reload pulse, then let the pin pipeline settle
	task wait_evt;
		while (evt !== 1'b1) @(posedge clk);
		repeat (12) @(posedge clk);
	endtask : wait_evt
	task t_reset;
		repeat (3) @(posedge clk);
		chk(hi_oe, 3'h0);
		chk(hi, 3'h7);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		chk({hi_oe, lo_oe}, 6'h00);
		rstn <= 1'b0;
		mc_en <= 1'b1;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		chk({hi_oe, lo_oe, hi, lo}, 12'hff8);
	endtask : t_reset
	task t_regs;
		apb(1'b0, 8'h08, 32'h0);
		chk(rdata, 32'hfff);
		apb(1'b1, 8'h3c, 32'h5);
		chk(serr, 1'b1);
	endtask : t_regs
	task t_edge;
		apb(1'b1, 8'h08, 32'h9);
		apb(1'b1, 8'h20, 32'h4);
		apb(1'b1, 8'h24, 32'hffff);
		apb(1'b1, 8'h2c, 32'h64);
		apb(1'b1, 8'h04, 32'h1);
		apb(1'b1, 8'h00, 32'h3);
		wait_evt();
		run_len(0, 1'b1, n);
		chk(n, 4);
		run_len(0, 1'b0, n);
		chk(n, 6);
		cnt_on(3, n);
		chk(n, 0);
		cnt_on(4, n);
		chk(n, 20);
	endtask : t_edge
	task t_buffer;
		apb(1'b1, 8'h20, 32'h6);
		repeat (30) @(posedge clk);
		run_len(0, 1'b1, n);
		chk(n, 4);
		apb(1'b1, 8'h00, 32'h3);
		wait_evt();
		apb(1'b0, 8'h00, 32'h0);
		chk(rdata[1], 1'b0);
		run_len(0, 1'b1, n);
		chk(n, 6);
	endtask : t_buffer
	task t_div;
		apb(1'b1, 8'h04, 32'h41);
		apb(1'b1, 8'h00, 32'h7);
		wait_evt();
		run_len(0, 1'b1, n);
		chk(n, 12);
		run_len(7, 1'b0, n);
		chk(n + 1, 20);
	endtask : t_div
	task t_center;
		apb(1'b1, 8'h04, 32'h1);
		apb(1'b1, 8'h00, 32'h17);
		wait_evt();
		run_len(7, 1'b0, n);
		chk(n + 1, 9);
		run_len(7, 1'b0, n);
		chk(n + 1, 9);
	endtask : t_center
	task t_dead;
		apb(1'b1, 8'h04, 32'h0);
		apb(1'b1, 8'h0c, 32'h2);
		apb(1'b1, 8'h20, 32'h4);
		apb(1'b1, 8'h00, 32'h3);
		wait_evt();
		pair_chk <= 1'b1;
		run_len(0, 1'b1, n);
		chk(n, 2);
		run_len(3, 1'b1, n);
		chk(n, 4);
		chk(overlap, 0);
		apb(1'b1, 8'h1c, 32'h1);
		apb(1'b1, 8'h18, 32'h1);
		cnt_on(5, n);
		chk(n, 4);
	endtask : t_dead
	task t_ovr;
		apb(1'b1, 8'h14, 32'h1);
		apb(1'b1, 8'h00, 32'h9);
		repeat (12) @(posedge clk);
		cnt_on(0, n);
		chk(n, 0);
		cnt_on(3, n);
		chk(n, 8);
	endtask : t_ovr
	// Longest path is the first 4096-cycle period at reset reload
	initial begin
		#(40 * 100000);
		n_errors++;
		finish_test();
	end
	initial begin
		t_reset();
		t_regs();
		t_edge();
		t_buffer();
		t_div();
		t_center();
		t_dead();
		t_ovr();
		finish_test();
	end
endmodule : mmm_modulator_bench
